//--- bench/bsc_chk.sv
`timescale 1ns/100ps
// Port-level checks; link checks on rising tck
module bsc_chk (
    input wire logic                       sys_clk,
    input wire logic                       nrst,
    input wire logic                       tck,
    input wire logic                       tms,
    input wire logic                       tdo_oe,
    input wire logic [bsc_pkg::N_PINS-1:0] pin_oe,
    input wire logic                       pins_pullup,
    input wire logic [bsc_pkg::CFG_W-1:0]  cfg_word,
    input wire logic                       secure_locked,
    input wire logic [bsc_pkg::CNT_W-1:0]  burns_done
);
    property p_pull; @(posedge sys_clk) disable iff (!nrst)
        pins_pullup |-> pin_oe == '0; endproperty
    a_pull: assert property (p_pull) else $error("pins driven");
    // Latch only moves at power-up, so three settled cycles first
    property p_sec; @(posedge sys_clk) disable iff (!nrst)
        $past(nrst, 3) |-> $stable(secure_locked); endproperty
    a_sec: assert property (p_sec) else $error("security moved");
    property p_lock; @(posedge sys_clk) disable iff (!nrst)
        $past(nrst, 3) && secure_locked |-> $stable(cfg_word); endproperty
    a_lock: assert property (p_lock) else $error("locked reload");
    property p_cap; @(posedge sys_clk) disable iff (!nrst)
        burns_done <= bsc_pkg::MAX_BURNS; endproperty
    a_cap: assert property (p_cap) else $error("burn cap");
    property p_step; @(posedge sys_clk) disable iff (!nrst)
        $changed(burns_done) |-> burns_done == $past(burns_done) + 7'h01;
    endproperty
    a_step: assert property (p_step) else $error("burn step");
    property p_on; @(posedge tck) disable iff (!nrst)
        $rose(tdo_oe) |-> !$past(tms); endproperty
    a_on: assert property (p_on) else $error("shift entry");
    property p_off; @(posedge tck) disable iff (!nrst)
        $fell(tdo_oe) |-> $past(tms); endproperty
    a_off: assert property (p_off) else $error("shift exit");
    property p_tlr; @(posedge tck) disable iff (!nrst)
        tms [*5] |=> !tdo_oe; endproperty
    a_tlr: assert property (p_tlr) else $error("no logic reset");
endmodule : bsc_chk
////////////////////////////////
bind bsc_top bsc_chk u_chk (.sys_clk(sys_clk), .nrst(nrst), .tck(tck),
    .tms(tms), .tdo_oe(tdo_oe), .pin_oe(pin_oe), .pins_pullup(pins_pullup),
    .cfg_word(cfg_word), .secure_locked(secure_locked),
    .burns_done(burns_done));

//--- bench/bsc_ctl_model.sv
`timescale 1ns/100ps
// Scan controller; tck stands low outside frames
module bsc_ctl_model (
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // Change after falling tck, sample tdo just before rising
    task automatic step(input logic m, input logic b, output logic o);
        tms = m;
        tdi = b;
        #62.5;
        o = tdo;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask : step
    // Full IR or DR scan from idle back to idle, LSB first
    task automatic scan(input bit ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic o;
        dout = '0;
        step(1'b0, 1'b0, o);
        step(1'b1, 1'b0, o);
        if (ir) step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        step(1'b0, 1'b0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
    endtask : scan
endmodule : bsc_ctl_model

//--- bench/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic                       sys_clk = 1'b0;
    logic                       nrst = 1'b0;
    logic                       vpp_ok = 1'b0;
    logic                       tck, tms, tdi, tdo, pins_pullup, sec;
    logic [bsc_pkg::N_PINS-1:0] c_out = '0, c_oe = '0, p_in = '0;
    logic [bsc_pkg::N_PINS-1:0] p_out, p_oe;
    logic [bsc_pkg::CFG_W-1:0]  cfg_word;
    logic [bsc_pkg::CNT_W-1:0]  burns_done;
    logic [63:0]                d, v;
    logic [31:0]                seed = 32'h0001_628B;
    logic [4:0]                 codes [4] = '{5'h1F, 5'h03, 5'h11, 5'h1E};
    int                         bad_count = 0, check_count = 0, cyc = 0;
    always #50 sys_clk = ~sys_clk;
    bsc_top #(.LARGE(1'b1)) uut (.sys_clk(sys_clk), .nrst(nrst), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(), .vpp_ok(vpp_ok),
        .core_out(c_out), .core_oe(c_oe), .pin_in(p_in), .pin_out(p_out),
        .pin_oe(p_oe), .pins_pullup(pins_pullup), .cfg_word(cfg_word),
        .secure_locked(sec), .burns_done(burns_done));
    bsc_ctl_model u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    ////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %0h exp %0h", $time, g, e);
        end
    endtask : chk
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // Scans leave time for the sys-side snapshot and pin update
    task automatic ir(input logic [4:0] c);
        u_ctl.scan(1'b1, 5, {59'h0, c}, d);
        wt(8);
    endtask : ir
    task automatic dr(input int n, input logic [63:0] x);
        u_ctl.scan(1'b0, n, x, d);
        wt(6);
    endtask : dr
    // Hang guard, far above the expected run
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            final_report();
        end
    end
    ////////////////////////////////
    initial begin
        logic o;
        u_ctl.step(1'b1, 1'b0, o);
        u_ctl.step(1'b1, 1'b0, o);
        wt(3);
        c_out = 8'(rnd());
        c_oe = 8'(rnd());
        nrst = 1'b1;
        wt(6);
        chk(pins_pullup, 64'h0);
        chk(cfg_word, bsc_pkg::NV_CFG_RST);
        dr(32, 64'h0);
        chk(d, bsc_pkg::ID_VALUE);
        $display("idcode test done");
        foreach (codes[i]) begin
            ir(codes[i]);
            chk(d, 64'h1);
            v = {32'h0, rnd()};
            dr(16, v);
            chk(d, {v[14:0], 1'b0});
            chk(p_oe, c_oe);
        end
        repeat (5) u_ctl.step(1'b1, 1'b0, o);
        dr(32, 64'h0);
        chk(d, bsc_pkg::ID_VALUE);
        $display("bypass test done");
        p_in = 8'(rnd());
        ir(bsc_pkg::I_SAMPLE);
        v = {56'h0, 8'(rnd())};
        dr(8, v);
        chk(d, p_in);
        ir(bsc_pkg::I_EXTEST);
        chk(p_oe, 8'hFF);
        chk(p_out, v[7:0]);
        ir(bsc_pkg::I_FLOAT);
        chk(p_oe, 8'h00);
        $display("pin test done");
        ir(bsc_pkg::I_RELOAD);
        chk(p_oe, 8'h00);
        chk(pins_pullup, 64'h1);
        repeat (2) begin
            v = {48'h0, 16'(rnd())};
            dr(16, v);
            chk(cfg_word, v);
        end
        ir(bsc_pkg::I_READBACK);
        dr(16, 64'h0);
        chk(d, v);
        $display("reload test done");
        ir(bsc_pkg::I_BURN);
        chk(p_oe, 8'h00);
        v = {31'h0, 1'b1, rnd()};
        dr(33, v);
        chk(burns_done, 64'h0);
        vpp_ok = 1'b1;
        wt(4);
        repeat (101) dr(33, v);
        chk(burns_done, bsc_pkg::MAX_BURNS);
        chk(sec, 64'h0);
        ir(bsc_pkg::I_USERSIG);
        dr(16, 64'h0);
        chk(d, v[31:16]);
        $display("burn test done");
        final_report();
    end
endmodule : testbench

//--- core/bsc_pkg.sv
package bsc_pkg;
    localparam int IR_W    = 5;
    localparam int N_PINS  = 8;
    localparam int CFG_W   = 16;
    localparam int SIG_W   = 16;
    localparam int ID_W    = 32;
    localparam int DR_W    = 33;
    localparam int LEN_W   = 6;
    localparam int CNT_W   = 7;

    // Instruction codes
    localparam logic [IR_W-1:0] I_EXTEST   = 5'h00;
    localparam logic [IR_W-1:0] I_SAMPLE   = 5'h01;
    localparam logic [IR_W-1:0] I_IDCODE   = 5'h02;
    localparam logic [IR_W-1:0] I_RELOAD   = 5'h08;
    localparam logic [IR_W-1:0] I_BURN     = 5'h09;
    localparam logic [IR_W-1:0] I_READBACK = 5'h0A;
    localparam logic [IR_W-1:0] I_USERSIG  = 5'h16;
    localparam logic [IR_W-1:0] I_FLOAT    = 5'h1D;
    localparam logic [IR_W-1:0] I_BYPASS   = 5'h1F;
    localparam logic [IR_W-1:0] IR_CAPTURE = 5'h01;

    // Data register lengths per instruction
    localparam logic [LEN_W-1:0] LEN_BYP  = 6'h01;
    localparam logic [LEN_W-1:0] LEN_BND  = 6'h08;
    localparam logic [LEN_W-1:0] LEN_ID   = 6'h20;
    localparam logic [LEN_W-1:0] LEN_CFG  = 6'h10;
    localparam logic [LEN_W-1:0] LEN_SIG  = 6'h10;
    localparam logic [LEN_W-1:0] LEN_BURN = 6'h21;

    // Burn payload layout: {security, signature, configuration}
    localparam int BURN_SIG_LSB = 16;
    localparam int BURN_SEC_BIT = 32;

    // Identification value is arbitrary; bit 0 stays set
    localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_5A01;

    // Burn budget of the nonvolatile cells
    localparam logic [CNT_W-1:0] MAX_BURNS = 7'h64;

    // Nonvolatile contents at cold start
    localparam logic [CFG_W-1:0] NV_CFG_RST = 16'h0000;
    localparam logic [SIG_W-1:0] NV_SIG_RST = 16'h0000;
    localparam logic             NV_SEC_RST = 1'b0;

    // Update payload kinds
    localparam logic [1:0] K_BND    = 2'h0;
    localparam logic [1:0] K_RELOAD = 2'h1;
    localparam logic [1:0] K_BURN   = 2'h2;

    typedef enum logic [3:0] {
        ST_RESET    = 4'h0,
        ST_IDLE     = 4'h1,
        ST_SEL_DR   = 4'h3,
        ST_CAP_DR   = 4'h2,
        ST_SH_DR    = 4'h6,
        ST_EX1_DR   = 4'h7,
        ST_PAUSE_DR = 4'h5,
        ST_EX2_DR   = 4'h4,
        ST_UPD_DR   = 4'hC,
        ST_SEL_IR   = 4'hD,
        ST_CAP_IR   = 4'hF,
        ST_SH_IR    = 4'hE,
        ST_EX1_IR   = 4'hA,
        ST_PAUSE_IR = 4'hB,
        ST_EX2_IR   = 4'h9,
        ST_UPD_IR   = 4'h8
    } bsc_tap_state_t;

    typedef enum logic [1:0] {
        SYS_BOOT = 2'h0,
        SYS_RUN  = 2'h1
    } bsc_sys_state_t;
endpackage : bsc_pkg

//--- core/bsc_sync2.sv
`timescale 1ns/100ps
// Two-stage level synchroniser; first stage feeds only the second
module bsc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : bsc_sync2

//--- core/bsc_tap_fsm.sv
`timescale 1ns/100ps
// Sixteen-state test controller, stepped on rising TCK
module bsc_tap_fsm (
    input  wire logic tck,
    input  wire logic nrst,
    input  wire logic tms,
    bsc_tap_if.fsm    tap
);
    bsc_pkg::bsc_tap_state_t st_q;
    bsc_pkg::bsc_tap_state_t st_d;

    // Next state from TMS
    always_comb begin
        case (st_q)
            bsc_pkg::ST_RESET:    st_d = tms ? bsc_pkg::ST_RESET
                                             : bsc_pkg::ST_IDLE;
            bsc_pkg::ST_IDLE:     st_d = tms ? bsc_pkg::ST_SEL_DR
                                             : bsc_pkg::ST_IDLE;
            bsc_pkg::ST_SEL_DR:   st_d = tms ? bsc_pkg::ST_SEL_IR
                                             : bsc_pkg::ST_CAP_DR;
            bsc_pkg::ST_CAP_DR:   st_d = tms ? bsc_pkg::ST_EX1_DR
                                             : bsc_pkg::ST_SH_DR;
            bsc_pkg::ST_SH_DR:    st_d = tms ? bsc_pkg::ST_EX1_DR
                                             : bsc_pkg::ST_SH_DR;
            bsc_pkg::ST_EX1_DR:   st_d = tms ? bsc_pkg::ST_UPD_DR
                                             : bsc_pkg::ST_PAUSE_DR;
            bsc_pkg::ST_PAUSE_DR: st_d = tms ? bsc_pkg::ST_EX2_DR
                                             : bsc_pkg::ST_PAUSE_DR;
            bsc_pkg::ST_EX2_DR:   st_d = tms ? bsc_pkg::ST_UPD_DR
                                             : bsc_pkg::ST_SH_DR;
            bsc_pkg::ST_UPD_DR:   st_d = tms ? bsc_pkg::ST_SEL_DR
                                             : bsc_pkg::ST_IDLE;
            bsc_pkg::ST_SEL_IR:   st_d = tms ? bsc_pkg::ST_RESET
                                             : bsc_pkg::ST_CAP_IR;
            bsc_pkg::ST_CAP_IR:   st_d = tms ? bsc_pkg::ST_EX1_IR
                                             : bsc_pkg::ST_SH_IR;
            bsc_pkg::ST_SH_IR:    st_d = tms ? bsc_pkg::ST_EX1_IR
                                             : bsc_pkg::ST_SH_IR;
            bsc_pkg::ST_EX1_IR:   st_d = tms ? bsc_pkg::ST_UPD_IR
                                             : bsc_pkg::ST_PAUSE_IR;
            bsc_pkg::ST_PAUSE_IR: st_d = tms ? bsc_pkg::ST_EX2_IR
                                             : bsc_pkg::ST_PAUSE_IR;
            bsc_pkg::ST_EX2_IR:   st_d = tms ? bsc_pkg::ST_UPD_IR
                                             : bsc_pkg::ST_SH_IR;
            bsc_pkg::ST_UPD_IR:   st_d = tms ? bsc_pkg::ST_SEL_DR
                                             : bsc_pkg::ST_IDLE;
            default:              st_d = bsc_pkg::ST_RESET;
        endcase
    end

    // State register, TMS taken on rising TCK
    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            st_q <= bsc_pkg::ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Phase strobes decoded from the current state
    assign tap.logic_reset = (st_q == bsc_pkg::ST_RESET);
    assign tap.capture_dr  = (st_q == bsc_pkg::ST_CAP_DR);
    assign tap.shift_dr    = (st_q == bsc_pkg::ST_SH_DR);
    assign tap.update_dr   = (st_q == bsc_pkg::ST_UPD_DR);
    assign tap.capture_ir  = (st_q == bsc_pkg::ST_CAP_IR);
    assign tap.shift_ir    = (st_q == bsc_pkg::ST_SH_IR);
    assign tap.update_ir   = (st_q == bsc_pkg::ST_UPD_IR);
endmodule : bsc_tap_fsm

//--- core/bsc_tap_if.sv
`timescale 1ns/100ps
// Controller phase strobes, all in the TCK domain
interface bsc_tap_if;
    logic logic_reset;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;

    modport fsm  (output logic_reset, capture_dr, shift_dr, update_dr,
                  capture_ir, shift_ir, update_ir);
    modport user (input  logic_reset, capture_dr, shift_dr, update_dr,
                  capture_ir, shift_ir, update_ir);
endinterface : bsc_tap_if

//--- core/bsc_top.sv
`timescale 1ns/100ps
// One scan and configuration port; LARGE only enables the pull-ups
module bsc_top #(
    parameter bit LARGE = 1'b1
) (
    input  wire logic                        sys_clk,
    input  wire logic                        nrst,
    input  wire logic                        tck,
    input  wire logic                        tms,
    input  wire logic                        tdi,
    output logic                             tdo,
    output logic                             tdo_oe,
    input  wire logic                        vpp_ok,
    input  wire logic [bsc_pkg::N_PINS-1:0]  core_out,
    input  wire logic [bsc_pkg::N_PINS-1:0]  core_oe,
    input  wire logic [bsc_pkg::N_PINS-1:0]  pin_in,
    output logic      [bsc_pkg::N_PINS-1:0]  pin_out,
    output logic      [bsc_pkg::N_PINS-1:0]  pin_oe,
    output logic                             pins_pullup,
    output logic      [bsc_pkg::CFG_W-1:0]   cfg_word,
    output logic                             secure_locked,
    output logic      [bsc_pkg::CNT_W-1:0]   burns_done
);
    localparam int N  = bsc_pkg::N_PINS;
    localparam int DW = bsc_pkg::DR_W;

    bsc_tap_if tap ();

    ////////////////////////////////////////////////////////////////////
    // TCK domain
    ////////////////////////////////////////////////////////////////////
    logic [bsc_pkg::IR_W-1:0]  ir_sh_q, ir_sh_d, ir_q, ir_d;
    logic [DW-1:0]             dr_q, dr_d, upd_data_q, upd_data_d;
    logic [1:0]                upd_kind_q, upd_kind_d;
    logic                      upd_tgl_q, upd_tgl_d;
    logic                      req_tgl_q, req_tgl_d;
    logic [bsc_pkg::LEN_W-1:0] dr_len;
    logic [N-1:0]              pin_tck;
    logic                      ack_tck;
    logic                      snap_ok;
    logic [3:0]                mode_tck;

    // Sys-domain snapshot, read only while the handshake is settled
    logic [bsc_pkg::CFG_W-1:0] pub_cfg_q, pub_cfg_d;
    logic [bsc_pkg::SIG_W-1:0] pub_sig_q, pub_sig_d;
    logic                      ack_tgl_q, ack_tgl_d;

    bsc_tap_fsm u_fsm (
        .tck  (tck),
        .nrst (nrst),
        .tms  (tms),
        .tap  (tap.fsm)
    );

    // Pins come from outside, so they settle before capture
    bsc_sync2 #(.W(N)) u_pin_sync (
        .clk  (tck),
        .nrst (nrst),
        .d    (pin_in),
        .q    (pin_tck)
    );

    bsc_sync2 #(.W(1)) u_ack_sync (
        .clk  (tck),
        .nrst (nrst),
        .d    (ack_tgl_q),
        .q    (ack_tck)
    );

    assign snap_ok = (ack_tck == req_tgl_q);

    // Selected data register length by instruction
    always_comb begin
        case (ir_q)
            bsc_pkg::I_EXTEST:   dr_len = bsc_pkg::LEN_BND;
            bsc_pkg::I_SAMPLE:   dr_len = bsc_pkg::LEN_BND;
            bsc_pkg::I_IDCODE:   dr_len = bsc_pkg::LEN_ID;
            bsc_pkg::I_USERSIG:  dr_len = bsc_pkg::LEN_SIG;
            bsc_pkg::I_RELOAD:   dr_len = bsc_pkg::LEN_CFG;
            bsc_pkg::I_READBACK: dr_len = bsc_pkg::LEN_CFG;
            bsc_pkg::I_BURN:     dr_len = bsc_pkg::LEN_BURN;
            default:             dr_len = bsc_pkg::LEN_BYP;
        endcase
    end

    // Instruction and data shift paths
    always_comb begin
        ir_sh_d    = ir_sh_q;
        ir_d       = ir_q;
        dr_d       = dr_q;
        upd_data_d = upd_data_q;
        upd_kind_d = upd_kind_q;
        upd_tgl_d  = upd_tgl_q;
        req_tgl_d  = req_tgl_q;
        // Falling back to IDCODE must also tell sys that the mode moved
        if (tap.logic_reset && ir_q != bsc_pkg::I_IDCODE) begin
            ir_d      = bsc_pkg::I_IDCODE;
            req_tgl_d = ~req_tgl_q;
        end
        if (tap.capture_ir) begin
            ir_sh_d = bsc_pkg::IR_CAPTURE;
        end else if (tap.shift_ir) begin
            ir_sh_d = {tdi, ir_sh_q[bsc_pkg::IR_W-1:1]};
        end else if (tap.update_ir) begin
            ir_d      = ir_sh_q;
            req_tgl_d = ~req_tgl_q; // Ask sys for a fresh snapshot
        end
        if (tap.capture_dr) begin
            dr_d = '0;
            case (ir_q)
                bsc_pkg::I_EXTEST,
                bsc_pkg::I_SAMPLE:   dr_d[N-1:0] = pin_tck;
                bsc_pkg::I_IDCODE:   dr_d[bsc_pkg::ID_W-1:0] =
                                         bsc_pkg::ID_VALUE;
                bsc_pkg::I_USERSIG:  if (snap_ok) begin
                    dr_d[bsc_pkg::SIG_W-1:0] = pub_sig_q;
                end
                bsc_pkg::I_READBACK: if (snap_ok) begin
                    dr_d[bsc_pkg::CFG_W-1:0] = pub_cfg_q;
                end
                default:             dr_d = '0;
            endcase
        end else if (tap.shift_dr) begin
            dr_d = {1'b0, dr_q[DW-1:1]};
            dr_d[dr_len - 6'h01] = tdi;
        end else if (tap.update_dr) begin
            case (ir_q)
                bsc_pkg::I_EXTEST,
                bsc_pkg::I_SAMPLE: begin
                    upd_data_d = dr_q;
                    upd_kind_d = bsc_pkg::K_BND;
                    upd_tgl_d  = ~upd_tgl_q;
                end
                bsc_pkg::I_RELOAD: begin
                    upd_data_d = dr_q;
                    upd_kind_d = bsc_pkg::K_RELOAD;
                    upd_tgl_d  = ~upd_tgl_q;
                end
                bsc_pkg::I_BURN: begin
                    upd_data_d = dr_q;
                    upd_kind_d = bsc_pkg::K_BURN;
                    upd_tgl_d  = ~upd_tgl_q;
                end
                default: upd_tgl_d = upd_tgl_q;
            endcase
        end
    end

    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            ir_sh_q    <= bsc_pkg::IR_CAPTURE;
            ir_q       <= bsc_pkg::I_IDCODE;
            dr_q       <= '0;
            upd_data_q <= '0;
            upd_kind_q <= bsc_pkg::K_BND;
            upd_tgl_q  <= 1'b0;
            req_tgl_q  <= 1'b0;
        end else begin
            ir_sh_q    <= ir_sh_d;
            ir_q       <= ir_d;
            dr_q       <= dr_d;
            upd_data_q <= upd_data_d;
            upd_kind_q <= upd_kind_d;
            upd_tgl_q  <= upd_tgl_d;
            req_tgl_q  <= req_tgl_d;
        end
    end

    // Modes that reach the pins: extest, float, reload, burn
    assign mode_tck = {ir_q == bsc_pkg::I_BURN,
                       ir_q == bsc_pkg::I_RELOAD,
                       ir_q == bsc_pkg::I_FLOAT,
                       ir_q == bsc_pkg::I_EXTEST};

    // TDO changes on falling TCK so the next device has a full half cycle
    always_ff @(negedge tck or negedge nrst) begin
        if (!nrst) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else begin
            tdo    <= tap.shift_ir ? ir_sh_q[0] : dr_q[0];
            tdo_oe <= tap.shift_ir | tap.shift_dr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // System clock domain
    ////////////////////////////////////////////////////////////////////
    logic [3:0]                mode_q, mode_d;
    logic                      upd_s, req_s, vpp_s;
    logic                      upd_seen_q, upd_seen_d;
    logic                      req_seen_q, req_seen_d;
    bsc_pkg::bsc_sys_state_t   sst_q, sst_d;
    logic [bsc_pkg::CFG_W-1:0] sram_q, sram_d, nv_cfg_q, nv_cfg_d;
    logic [bsc_pkg::SIG_W-1:0] nv_sig_q, nv_sig_d;
    logic                      nv_sec_q, nv_sec_d, sec_q, sec_d;
    logic [bsc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [N-1:0]              bnd_q, bnd_d, pout_d, poe_d;
    logic                      pull_d, upd_ev, req_ev, pins_off;

    bsc_sync2 #(.W(3)) u_evt_sync (
        .clk  (sys_clk),
        .nrst (nrst),
        .d    ({upd_tgl_q, req_tgl_q, vpp_ok}),
        .q    ({upd_s, req_s, vpp_s})
    );

    // Payload is stable from its toggle until the next Update-DR
    assign upd_ev = (upd_s != upd_seen_q);
    assign req_ev = (req_s != req_seen_q);

    // Boot copy, reloads, burns and snapshots
    always_comb begin
        sst_d      = sst_q;
        sram_d     = sram_q;
        nv_cfg_d   = nv_cfg_q;
        nv_sig_d   = nv_sig_q;
        nv_sec_d   = nv_sec_q;
        sec_d      = sec_q;
        cnt_d      = cnt_q;
        bnd_d      = bnd_q;
        pub_cfg_d  = pub_cfg_q;
        pub_sig_d  = pub_sig_q;
        ack_tgl_d  = ack_tgl_q;
        mode_d     = mode_q;
        upd_seen_d = upd_s;
        req_seen_d = req_s;
        case (sst_q)
            bsc_pkg::SYS_BOOT: begin
                sram_d = nv_cfg_q;
                sec_d  = nv_sec_q;
                sst_d  = bsc_pkg::SYS_RUN;
                // Hold events until the copy is done
                upd_seen_d = upd_seen_q;
                req_seen_d = req_seen_q;
            end
            bsc_pkg::SYS_RUN: begin
                if (upd_ev) begin
                    case (upd_kind_q)
                        bsc_pkg::K_BND: bnd_d = upd_data_q[N-1:0];
                        bsc_pkg::K_RELOAD: if (!sec_q) begin
                            sram_d = upd_data_q[bsc_pkg::CFG_W-1:0];
                        end
                        bsc_pkg::K_BURN:
                            if (vpp_s && cnt_q < bsc_pkg::MAX_BURNS) begin
                                nv_cfg_d = upd_data_q[bsc_pkg::CFG_W-1:0];
                                nv_sig_d = upd_data_q[
                                    bsc_pkg::BURN_SIG_LSB +: bsc_pkg::SIG_W];
                                nv_sec_d = upd_data_q[bsc_pkg::BURN_SEC_BIT];
                                cnt_d    = cnt_q + 7'h01;
                            end
                        default: bnd_d = bnd_q;
                    endcase
                end
                if (req_ev) begin
                    // Locked part reads back zero configuration; the signature is still read
                    pub_cfg_d = sec_q ? '0 : sram_q;
                    pub_sig_d = nv_sig_q;
                    ack_tgl_d = req_s;
                    // Mode word has settled since its toggle left tck
                    mode_d    = mode_tck;
                end
            end
            default: sst_d = bsc_pkg::SYS_BOOT;
        endcase
    end

    // Pin drive: float and reload/burn override extest and core
    always_comb begin
        pins_off = mode_q[1] | mode_q[2] | mode_q[3]
                 | (sst_q == bsc_pkg::SYS_BOOT);
        if (pins_off) begin
            pout_d = '0;
            poe_d  = '0;
        end else if (mode_q[0]) begin
            pout_d = bnd_q;
            poe_d  = '1;
        end else begin
            pout_d = core_out;
            poe_d  = core_oe;
        end
        pull_d = LARGE & ((sst_q == bsc_pkg::SYS_BOOT)
                        | mode_q[2] | mode_q[3]);
    end

    // Nonvolatile cells reset only at a cold start
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sst_q         <= bsc_pkg::SYS_BOOT;
            sram_q        <= bsc_pkg::NV_CFG_RST;
            nv_cfg_q      <= bsc_pkg::NV_CFG_RST;
            nv_sig_q      <= bsc_pkg::NV_SIG_RST;
            nv_sec_q      <= bsc_pkg::NV_SEC_RST;
            sec_q         <= bsc_pkg::NV_SEC_RST;
            cnt_q         <= '0;
            bnd_q         <= '0;
            pub_cfg_q     <= '0;
            pub_sig_q     <= '0;
            ack_tgl_q     <= 1'b0;
            mode_q        <= '0;
            upd_seen_q    <= 1'b0;
            req_seen_q    <= 1'b0;
            pin_out       <= '0;
            pin_oe        <= '0;
            pins_pullup   <= 1'b0;
            cfg_word      <= '0;
            secure_locked <= 1'b0;
            burns_done    <= '0;
        end else begin
            sst_q         <= sst_d;
            sram_q        <= sram_d;
            nv_cfg_q      <= nv_cfg_d;
            nv_sig_q      <= nv_sig_d;
            nv_sec_q      <= nv_sec_d;
            sec_q         <= sec_d;
            cnt_q         <= cnt_d;
            bnd_q         <= bnd_d;
            pub_cfg_q     <= pub_cfg_d;
            pub_sig_q     <= pub_sig_d;
            ack_tgl_q     <= ack_tgl_d;
            mode_q        <= mode_d;
            upd_seen_q    <= upd_seen_d;
            req_seen_q    <= req_seen_d;
            pin_out       <= pout_d;
            pin_oe        <= poe_d;
            pins_pullup   <= pull_d;
            cfg_word      <= sram_q;
            secure_locked <= sec_q;
            burns_done    <= cnt_q;
        end
    end
endmodule : bsc_top
